// >>> fifo_flush_pkg.sv
// Constants, register map and field layout of the flushable FIFO channel.
package fifo_flush_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 6;
	localparam int DEPTH = 64;
	localparam int LEVEL_W = ADDR_W + 1;
	localparam int PADDR_W = 8;
	localparam int EVENT_W = 4;

	localparam logic [PADDR_W-1:0] CTRL_OFS = 8'h00;
	localparam logic [PADDR_W-1:0] START_OFS = 8'h04;
	localparam logic [PADDR_W-1:0] END_OFS = 8'h08;
	localparam logic [PADDR_W-1:0] LOW_MARK_OFS = 8'h0c;
	localparam logic [PADDR_W-1:0] HIGH_MARK_OFS = 8'h10;
	localparam logic [PADDR_W-1:0] STATUS_OFS = 8'h14;
	localparam logic [PADDR_W-1:0] LEVEL_OFS = 8'h18;
	localparam logic [PADDR_W-1:0] READ_PTR_OFS = 8'h1c;
	localparam logic [PADDR_W-1:0] WRITE_PTR_OFS = 8'h20;
	localparam logic [PADDR_W-1:0] DATA_OFS = 8'h24;
	localparam logic [PADDR_W-1:0] PENDING_OFS = 8'h28;
	localparam logic [PADDR_W-1:0] MASK_OFS = 8'h2c;

	localparam int FLUSH_BIT = 0;
	localparam int EMPTY_BIT = 0;
	localparam int FULL_BIT = 1;
	localparam int LOW_BIT = 2;
	localparam int HIGH_BIT = 3;

	localparam int EV_OVERFLOW = 0;
	localparam int EV_UNDERFLOW = 1;
	localparam int EV_LOW = 2;
	localparam int EV_HIGH = 3;

	localparam logic [ADDR_W-1:0] START_RESET = 6'h00;
	localparam logic [ADDR_W-1:0] END_RESET = 6'h3f;
	localparam logic [ADDR_W-1:0] LOW_MARK_RESET = 6'h08;
	localparam logic [ADDR_W-1:0] HIGH_MARK_RESET = 6'h38;
	localparam logic [ADDR_W-1:0] PTR_STEP = 6'h01;
	localparam logic [LEVEL_W-1:0] LEVEL_STEP = 7'h01;
	localparam logic [LEVEL_W-1:0] LEVEL_ZERO = 7'h00;
	localparam logic [EVENT_W-1:0] EVENT_NONE = 4'h0;
endpackage

// >>> fifo_word_store.sv
// Flip-flop word storage of the FIFO channel.
`timescale 1ns/10ps
module fifo_word_store (
	input wire logic core_clk,
	input wire logic writeEnable,
	input wire logic [fifo_flush_pkg::ADDR_W-1:0] writeIndex,
	input wire logic [fifo_flush_pkg::DATA_W-1:0] writeData,
	input wire logic [fifo_flush_pkg::ADDR_W-1:0] readIndex,
	output logic [fifo_flush_pkg::DATA_W-1:0] readData
);
	logic [fifo_flush_pkg::DATA_W-1:0] words [fifo_flush_pkg::DEPTH];

	always_ff @(posedge core_clk) begin
		if (writeEnable) begin
			words[writeIndex] <= writeData;
		end
	end

	assign readData = words[readIndex];
endmodule

// >>> fifo_channel_flush.sv
// One FIFO channel with APB registers, flush control and interrupts.
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/10ps
module fifo_channel_flush (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [fifo_flush_pkg::PADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [fifo_flush_pkg::DATA_W-1:0] pwdata,
	output logic [fifo_flush_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq
);
	localparam int AW = fifo_flush_pkg::ADDR_W;
	localparam int LW = fifo_flush_pkg::LEVEL_W;
	localparam int DW = fifo_flush_pkg::DATA_W;
	localparam int EW = fifo_flush_pkg::EVENT_W;

	logic [AW-1:0] startAddress, next_startAddress;
	logic [AW-1:0] endAddress, next_endAddress;
	logic [AW-1:0] low_mark_address, next_low_mark_address;
	logic [AW-1:0] high_mark_address, next_high_mark_address;
	logic [AW-1:0] read_pointer, next_read_pointer;
	logic [AW-1:0] write_pointer, next_write_pointer;
	logic [LW-1:0] fillLevel, next_fillLevel;
	logic emptyFlag, next_emptyFlag;
	logic fullFlag, next_fullFlag;
	logic below_low_mark_flag, next_below_low_mark_flag;
	logic above_high_mark_flag, next_above_high_mark_flag;
	logic [EW-1:0] interrupt_pending_flags, next_interrupt_pending_flags;
	logic [EW-1:0] interruptMask, next_interruptMask;
	logic [DW-1:0] next_prdata;
	logic next_pready, next_pslverr, next_irq;

	logic setupPhase, accessDone, writeDone, readDone;
	logic flushRequest, pushRequest, popRequest, pushOk, popOk;
	logic addrMapped;
	logic [LW-1:0] capacity;
	logic [EW-1:0] events, clearMask;
	logic [DW-1:0] storeData, readValue;
	logic [3:0] statusWord;

	fifo_word_store store (
		.core_clk(core_clk),
		.writeEnable(pushOk),
		.writeIndex(write_pointer),
		.writeData(pwdata),
		.readIndex(read_pointer),
		.readData(storeData)
	);

	function automatic logic [AW-1:0] advance(input logic [AW-1:0] ptr,
		input logic [AW-1:0] first, input logic [AW-1:0] last);
		if (ptr == last) begin
			advance = first;
		end else begin
			advance = ptr + fifo_flush_pkg::PTR_STEP;
		end
	endfunction

	always_comb begin
		setupPhase = psel & penable & ~pready;
		accessDone = psel & penable & pready;
		writeDone = accessDone & pwrite;
		readDone = accessDone & ~pwrite;
		flushRequest = writeDone && (paddr == fifo_flush_pkg::CTRL_OFS) &&
			pwdata[fifo_flush_pkg::FLUSH_BIT];
		pushRequest = writeDone && (paddr == fifo_flush_pkg::DATA_OFS);
		popRequest = readDone && (paddr == fifo_flush_pkg::DATA_OFS);
		pushOk = pushRequest & ~fullFlag & ~flushRequest;
		popOk = popRequest & ~emptyFlag;
		capacity = {1'b0, endAddress} - {1'b0, startAddress} +
			fifo_flush_pkg::LEVEL_STEP;
		clearMask = fifo_flush_pkg::EVENT_NONE;
		if (writeDone && (paddr == fifo_flush_pkg::PENDING_OFS)) begin
			clearMask = pwdata[EW-1:0];
		end

		next_startAddress = startAddress;
		next_endAddress = endAddress;
		next_low_mark_address = low_mark_address;
		next_high_mark_address = high_mark_address;
		next_interruptMask = interruptMask;
		if (writeDone) begin
			unique case (paddr)
				fifo_flush_pkg::START_OFS: next_startAddress = pwdata[AW-1:0];
				fifo_flush_pkg::END_OFS: next_endAddress = pwdata[AW-1:0];
				fifo_flush_pkg::LOW_MARK_OFS:
					next_low_mark_address = pwdata[AW-1:0];
				fifo_flush_pkg::HIGH_MARK_OFS:
					next_high_mark_address = pwdata[AW-1:0];
				fifo_flush_pkg::MASK_OFS: next_interruptMask = pwdata[EW-1:0];
				default: begin
				end
			endcase
		end

		next_read_pointer = read_pointer;
		next_write_pointer = write_pointer;
		next_fillLevel = fillLevel;
		if (flushRequest) begin
			// Pointers take the configured start, not their reset value.
			next_read_pointer = startAddress;
			next_write_pointer = startAddress;
			next_fillLevel = fifo_flush_pkg::LEVEL_ZERO;
		end else begin
			if (pushOk) begin
				next_write_pointer = advance(write_pointer, startAddress,
					endAddress);
			end
			if (popOk) begin
				next_read_pointer = advance(read_pointer, startAddress,
					endAddress);
			end
			if (pushOk && !popOk) begin
				next_fillLevel = fillLevel + fifo_flush_pkg::LEVEL_STEP;
			end else if (popOk && !pushOk) begin
				next_fillLevel = fillLevel - fifo_flush_pkg::LEVEL_STEP;
			end
		end

		if (flushRequest) begin
			next_emptyFlag = 1'b1;
			next_fullFlag = 1'b0;
		end else begin
			next_emptyFlag = (next_fillLevel == fifo_flush_pkg::LEVEL_ZERO);
			next_fullFlag = (next_fillLevel == capacity);
		end
		// Marks are compared against the new level, which is zero on flush.
		next_below_low_mark_flag = next_fillLevel <
			{1'b0, next_low_mark_address};
		next_above_high_mark_flag = (next_high_mark_address != '0) &&
			(next_fillLevel >= {1'b0, next_high_mark_address});

		events = fifo_flush_pkg::EVENT_NONE;
		events[fifo_flush_pkg::EV_OVERFLOW] = pushRequest & fullFlag &
			~flushRequest;
		events[fifo_flush_pkg::EV_UNDERFLOW] = popRequest & emptyFlag;
		// A flush raises no notification of its own.
		events[fifo_flush_pkg::EV_LOW] = ~flushRequest &
			next_below_low_mark_flag & ~below_low_mark_flag;
		events[fifo_flush_pkg::EV_HIGH] = ~flushRequest &
			next_above_high_mark_flag & ~above_high_mark_flag;
		// A new event wins over a clear in the same cycle.
		next_interrupt_pending_flags = (interrupt_pending_flags & ~clearMask) |
			events;
		next_irq = |(next_interrupt_pending_flags & next_interruptMask);

		statusWord = '0;
		statusWord[fifo_flush_pkg::EMPTY_BIT] = emptyFlag;
		statusWord[fifo_flush_pkg::FULL_BIT] = fullFlag;
		statusWord[fifo_flush_pkg::LOW_BIT] = below_low_mark_flag;
		statusWord[fifo_flush_pkg::HIGH_BIT] = above_high_mark_flag;

		addrMapped = 1'b1;
		readValue = '0;
		unique case (paddr)
			// The flush bit is never stored, so control reads zero.
			fifo_flush_pkg::CTRL_OFS: readValue = '0;
			fifo_flush_pkg::START_OFS: readValue[AW-1:0] = startAddress;
			fifo_flush_pkg::END_OFS: readValue[AW-1:0] = endAddress;
			fifo_flush_pkg::LOW_MARK_OFS:
				readValue[AW-1:0] = low_mark_address;
			fifo_flush_pkg::HIGH_MARK_OFS:
				readValue[AW-1:0] = high_mark_address;
			fifo_flush_pkg::STATUS_OFS: readValue[3:0] = statusWord;
			fifo_flush_pkg::LEVEL_OFS: readValue[LW-1:0] = fillLevel;
			fifo_flush_pkg::READ_PTR_OFS: readValue[AW-1:0] = read_pointer;
			fifo_flush_pkg::WRITE_PTR_OFS:
				readValue[AW-1:0] = write_pointer;
			fifo_flush_pkg::DATA_OFS: begin
				if (!emptyFlag) begin
					readValue = storeData;
				end
			end
			fifo_flush_pkg::PENDING_OFS:
				readValue[EW-1:0] = interrupt_pending_flags;
			fifo_flush_pkg::MASK_OFS: readValue[EW-1:0] = interruptMask;
			default: addrMapped = 1'b0;
		endcase

		// One wait state: the answer is prepared while pready is low.
		next_pready = setupPhase;
		next_prdata = prdata;
		next_pslverr = 1'b0;
		if (setupPhase) begin
			// A write answer leaves the last read data standing.
			if (!pwrite) begin
				next_prdata = readValue;
			end
			next_pslverr = ~addrMapped;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			startAddress <= fifo_flush_pkg::START_RESET;
			endAddress <= fifo_flush_pkg::END_RESET;
			low_mark_address <= fifo_flush_pkg::LOW_MARK_RESET;
			high_mark_address <= fifo_flush_pkg::HIGH_MARK_RESET;
			read_pointer <= fifo_flush_pkg::START_RESET;
			write_pointer <= fifo_flush_pkg::START_RESET;
			fillLevel <= fifo_flush_pkg::LEVEL_ZERO;
			emptyFlag <= 1'b1;
			fullFlag <= 1'b0;
			below_low_mark_flag <= 1'b1;
			above_high_mark_flag <= 1'b0;
			interrupt_pending_flags <= fifo_flush_pkg::EVENT_NONE;
			interruptMask <= fifo_flush_pkg::EVENT_NONE;
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			irq <= 1'b0;
		end else begin
			startAddress <= next_startAddress;
			endAddress <= next_endAddress;
			low_mark_address <= next_low_mark_address;
			high_mark_address <= next_high_mark_address;
			read_pointer <= next_read_pointer;
			write_pointer <= next_write_pointer;
			fillLevel <= next_fillLevel;
			emptyFlag <= next_emptyFlag;
			fullFlag <= next_fullFlag;
			below_low_mark_flag <= next_below_low_mark_flag;
			above_high_mark_flag <= next_above_high_mark_flag;
			interrupt_pending_flags <= next_interrupt_pending_flags;
			interruptMask <= next_interruptMask;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
			irq <= next_irq;
		end
	end
endmodule

// >>> fifo_channel_flush_props.sv
// Concurrent checks on the APB ports of the FIFO channel.
`timescale 1ns/10ps
module fifo_channel_flush_props (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [fifo_flush_pkg::PADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [fifo_flush_pkg::DATA_W-1:0] pwdata,
	input wire logic [fifo_flush_pkg::DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic irq
);
	logic flushed;
	logic rdAck;
	assign rdAck = pready && !pwrite;
	// Marks an empty channel from a flush until the next push.
	always_ff @(posedge core_clk) begin
		if (!rstn)
			flushed <= 1'b0;
		else if (psel && penable && pready && pwrite && paddr == 8'h00)
			flushed <= pwdata[0] | flushed;
		else if (psel && penable && pready && pwrite && paddr == 8'h24)
			flushed <= 1'b0;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	a_ready_wait: assert property ($rose(penable) && psel |->
		!pready ##1 pready)
		else $error("pready not one wait state after access");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_ready_access: assert property (pready |-> psel && penable)
		else $error("pready outside an access phase");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_unmapped_err: assert property (pready && paddr > 8'h2c |->
		pslverr && (pwrite || prdata == 32'h0))
		else $error("unmapped access not refused");
	a_ctrl_zero: assert property (rdAck && paddr == 8'h00 |->
		prdata == 32'h0)
		else $error("control register reads nonzero");
	a_flush_level: assert property (flushed && rdAck &&
		paddr == 8'h18 |-> prdata == 32'h0)
		else $error("level not zero after flush");
	a_flush_status: assert property (flushed && rdAck &&
		paddr == 8'h14 |-> prdata[1:0] == 2'b01 && !prdata[3])
		else $error("status flags wrong after flush");
	a_rdata_hold: assert property (rdAck || $stable(prdata))
		else $error("prdata changed outside a read answer");
endmodule
bind fifo_channel_flush fifo_channel_flush_props uProps (.core_clk(core_clk),
	.rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .irq(irq));

// >>> apb_host.sv
// APB master model standing for the software that drives the channel.
`timescale 1ns/10ps
module apb_host (
	input wire logic core_clk,
	output logic [fifo_flush_pkg::PADDR_W-1:0] paddr,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [fifo_flush_pkg::DATA_W-1:0] pwdata,
	input wire logic [fifo_flush_pkg::DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial begin
		paddr = 8'h00;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		pwdata = 32'h0;
	end
	// Holds the whole request until pready is sampled high.
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule

// >>> testbench.sv
// Self-checking bench for the flushable FIFO channel.
`timescale 1ns/10ps
module testbench;
	typedef struct packed {
		logic [7:0] a;
		logic w;
		logic [31:0] d;
		logic [31:0] e;
	} row_t;
	logic core_clk, rstn, psel, penable, pwrite, pready, pslverr, irq, er;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	int mismatches = 0;
	int nTests = 0;
	row_t rows[$] = '{
		'{8'h00,0,0,'h0}, '{8'h04,0,0,'h0}, '{8'h08,0,0,'h3f},
		'{8'h0c,0,0,'h8}, '{8'h10,0,0,'h38}, '{8'h14,0,0,'h5},
		'{8'h18,0,0,'h0}, '{8'h28,0,0,'h0}, '{8'h2c,0,0,'h0},
		'{8'h04,1,'h10,0}, '{8'h08,1,'h13,0}, '{8'h0c,1,'h2,0},
		'{8'h10,1,'h3,0},
		'{8'h00,1,'h1,0}, '{8'h1c,0,0,'h10},
		'{8'h24,1,'h11,0}, '{8'h24,1,'h22,0}, '{8'h24,1,'h33,0},
		'{8'h24,1,'h44,0}, '{8'h18,0,0,'h4}, '{8'h14,0,0,'ha},
		'{8'h24,1,'h55,0}, '{8'h28,0,0,'h9}, '{8'h24,0,0,'h11},
		'{8'h24,1,'h66,0}, '{8'h1c,0,0,'h11}, '{8'h20,0,0,'h11},
		'{8'h2c,1,'hf,0}, '{8'h00,1,'h1,0},
		'{8'h00,0,0,'h0}, '{8'h18,0,0,'h0},
		'{8'h1c,0,0,'h10}, '{8'h20,0,0,'h10},
		'{8'h14,0,0,'h5}, '{8'h28,0,0,'h9},
		'{8'h24,0,0,'h0}, '{8'h28,0,0,'hb},
		'{8'h10,1,'h0,0}, '{8'h24,1,'h77,0}, '{8'h00,1,'h1,0},
		'{8'h14,0,0,'h5},
		'{8'h28,1,'hf,0}, '{8'h28,0,0,'h0},
		'{8'h04,1,'h0,0}, '{8'h0c,1,'h0,0},
		'{8'h00,1,'h1,0}, '{8'h1c,0,0,'h0},
		'{8'h20,0,0,'h0}, '{8'h14,0,0,'h1}
	};
	apb_host host (.core_clk(core_clk), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	fifo_channel_flush dut (.core_clk(core_clk), .rstn(rstn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
	initial core_clk = 1'b0;
	always #2 core_clk = ~core_clk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		nTests++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic conclude;
		if (mismatches == 0 && nTests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge core_clk);
		mismatches++;
		conclude();
	end
	initial begin
		rstn = 1'b0;
		repeat (8) @(posedge core_clk);
		rstn <= 1'b1;
		foreach (rows[i]) begin
			host.xfer(rows[i].a, rows[i].w, rows[i].d, rd, er);
			if (!rows[i].w)
				chk(rd, rows[i].e);
		end
		@(posedge core_clk);
		chk({31'h0, irq}, 32'h0);
		host.xfer(8'h24, 1'b0, 32'h0, rd, er);
		repeat (2) @(posedge core_clk);
		chk({31'h0, irq}, 32'h1);
		host.xfer(8'h00, 1'b1, 32'h1, rd, er);
		repeat (2) @(posedge core_clk);
		chk({31'h0, irq}, 32'h1);
		host.xfer(8'h2c, 1'b1, 32'h0, rd, er);
		repeat (2) @(posedge core_clk);
		chk({31'h0, irq}, 32'h0);
		host.xfer(8'h30, 1'b0, 32'h0, rd, er);
		chk(rd, 32'h0);
		chk({31'h0, er}, 32'h1);
		@(posedge core_clk);
		rstn <= 1'b0;
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		host.xfer(8'h04, 1'b0, 32'h0, rd, er);
		chk(rd, 32'h0);
		host.xfer(8'h28, 1'b0, 32'h0, rd, er);
		chk(rd, 32'h0);
		conclude();
	end
endmodule
